// *** rtl/cfg_word_pkg.sv ***
// Constants, field layouts and decoded-control types for the config word bank
// =============================================================================
package cfg_word_pkg;

    // =========================================================================
    // Word bank geometry
    localparam int          WORD_W    = 24;
    localparam int          NUM_WORDS = 10;
    localparam logic [15:0] CFG_BASE  = 16'hafec;  // First nonvolatile word
    localparam logic [15:0] CFG_STEP  = 16'h0002;

    // Word offsets are indices; the bus byte address is four times one
    localparam logic [15:0] IDX_RSVD_A     = 16'hafec;
    localparam logic [15:0] IDX_RSVD_B     = 16'hafee;
    localparam logic [15:0] IDX_DEBUG      = 16'haff0;
    localparam logic [15:0] IDX_WINPIN     = 16'haff2;
    localparam logic [15:0] IDX_WDOG       = 16'haff4;
    localparam logic [15:0] IDX_OSC        = 16'haff6;
    localparam logic [15:0] IDX_OSCSEL     = 16'haff8;
    localparam logic [15:0] IDX_SEGPROT    = 16'haffa;
    localparam logic [15:0] IDX_RSVD_C     = 16'haffc;
    localparam logic [15:0] IDX_RSVD_D     = 16'haffe;
    localparam logic [15:0] IDX_PART_ID    = 16'hb000;
    localparam logic [15:0] IDX_PART_REV   = 16'hb001;

    // Implemented-bit masks; zeros here read back as one
    localparam logic [23:0] MASK_RSVD    = 24'h000000;
    localparam logic [23:0] MASK_DEBUG   = 24'h000033;
    localparam logic [23:0] MASK_WINPIN  = 24'h0000f0;
    localparam logic [23:0] MASK_WDOG    = 24'h0000ff;
    localparam logic [23:0] MASK_OSC     = 24'h0000e7;
    localparam logic [23:0] MASK_OSCSEL  = 24'h0000c7;
    localparam logic [23:0] MASK_SEGPROT = 24'h000003;
    localparam logic [23:0] ERASED_WORD  = 24'hffffff;

    // Field positions
    localparam int DBG_CH_LSB    = 0;
    localparam int DBG_BSCAN_BIT = 5;
    localparam int WP_I2C1_BIT   = 4;
    localparam int WP_I2C2_BIT   = 5;
    localparam int WP_WIN_LSB    = 6;
    localparam int WD_POST_LSB   = 0;
    localparam int WD_PRE_BIT    = 4;
    localparam int WD_PLLK_BIT   = 5;
    localparam int WD_WDIS_BIT   = 6;
    localparam int WD_AON_BIT    = 7;
    localparam int OS_PMODE_LSB  = 0;
    localparam int OS_PINF_BIT   = 2;
    localparam int OS_1WAY_BIT   = 5;
    localparam int OS_CKSM_LSB   = 6;
    localparam int OSL_SEL_LSB   = 0;
    localparam int OSL_PWML_BIT  = 6;
    localparam int OSL_2SPD_BIT  = 7;
    localparam int SP_WRP_BIT    = 0;
    localparam int SP_CP_BIT     = 1;

    // Watchdog scaling constants
    localparam logic [7:0] PRESCALE_LONG  = 8'h80;  // 1:128
    localparam logic [7:0] PRESCALE_SHORT = 8'h20;  // 1:32

    // Identity codes: arbitrary neutral values
    localparam logic [23:0] PART_ID_DEFAULT  = 24'h00a5a5;
    localparam logic [23:0] PART_REV_DEFAULT = 24'h000001;

    // =========================================================================
    // Enumerations
    typedef enum logic [2:0] {
        CLK_FAST_RC      = 3'b000,
        CLK_FAST_RC_PLL  = 3'b001,
        CLK_PRI          = 3'b010,
        CLK_PRI_PLL      = 3'b011,
        CLK_RSVD_100     = 3'b100,
        CLK_LOW_POWER_RC = 3'b101,
        CLK_RSVD_110     = 3'b110,
        CLK_FAST_RC_DIV  = 3'b111
    } clk_src_t;

    typedef enum logic [1:0] {
        PRI_EXT_CLK = 2'b00,
        PRI_XTAL    = 2'b01,
        PRI_HS_XTAL = 2'b10,
        PRI_OFF     = 2'b11
    } pri_mode_t;

    typedef enum logic [1:0] {
        LD_IDLE = 2'b00,
        LD_REQ  = 2'b01,
        LD_WAIT = 2'b10,
        LD_DONE = 2'b11
    } load_state_t;

    // Decoded controls handed to other units
    typedef struct packed {
        logic      codeProtect;
        logic      writeProtect;
        logic      twoSpeedStartup;
        logic      pwmKeyLock;
        clk_src_t  oscillatorSelect;
        logic      clockSwitchEn;
        logic      failSafeEn;
        logic      oneWayRemap;
        logic      oscPinClockOut;
        pri_mode_t primaryOscMode;
        logic      watchdogAlwaysOn;
        logic      watchdogWindowed;
        logic [7:0] prescaleDiv;
        logic [3:0] postscaleShift;
        logic [3:0] windowEighths;     // Window size in eighths of period
        logic      port1PrimaryPins;
        logic      port2PrimaryPins;
        logic [1:0] debugPair;         // 1..3, 0 when code illegal
        logic      boundaryScanEn;
        logic      pllLockEn;
    } cfg_ctrl_t;

endpackage

// *** rtl/nonvolatile_config_word_decode.sv ***
// Configuration shadow-word loader, decoder and AHB-Lite read port
`timescale 1ns/100ps
module nonvolatile_config_word_decode
    import cfg_word_pkg::*;
#(
    parameter logic [23:0] PART_ID  = PART_ID_DEFAULT,   // Arbitrary value
    parameter logic [23:0] PART_REV = PART_REV_DEFAULT   // Arbitrary value
) (
    input  wire logic        mclk,
    input  wire logic        nrst,
    // Nonvolatile fetch port (same clock domain)
    output logic             nvmReq,
    output logic [15:0]      nvmAddr,
    input  wire logic        nvmAck,
    input  wire logic [23:0] nvmData,
    // Controls from other units
    input  wire logic        watchdogSoftEnable,
    input  wire logic        primaryClockReady,
    // Decoded controls
    output cfg_ctrl_t        cfgCtrl,
    output logic             configValid,
    output logic             watchdogRun,
    output logic             lowPowerRcRun,
    output logic             useFastRcStart,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp
);

    // =========================================================================
    // Shadow bank and loader state
    logic [WORD_W-1:0] shadow_q [NUM_WORDS];
    load_state_t       ldState_q;
    logic [3:0]        ldIdx_q;

    // Unimplemented bits forced to one as words enter the bank
    function automatic logic [23:0] fixWord(input logic [3:0] idx,
                                            input logic [23:0] raw);
        logic [23:0] m;
        m = MASK_RSVD;
        case (idx)
            4'h2:    m = MASK_DEBUG;
            4'h3:    m = MASK_WINPIN;
            4'h4:    m = MASK_WDOG;
            4'h5:    m = MASK_OSC;
            4'h6:    m = MASK_OSCSEL;
            4'h7:    m = MASK_SEGPROT;
            default: m = MASK_RSVD;
        endcase
        return (raw & m) | ~m;
    endfunction

    // =========================================================================
    // Loader: walks all words after every reset, then idles for good
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            ldState_q <= LD_IDLE;
            ldIdx_q   <= 4'h0;
        end else begin
            case (ldState_q)
                LD_IDLE: ldState_q <= LD_REQ;
                LD_REQ:  ldState_q <= LD_WAIT;
                LD_WAIT: begin
                    if (nvmAck) begin
                        if (ldIdx_q == 4'(NUM_WORDS - 1)) begin
                            ldState_q <= LD_DONE;
                        end else begin
                            ldIdx_q   <= ldIdx_q + 4'h1;
                            ldState_q <= LD_REQ;
                        end
                    end
                end
                LD_DONE: ldState_q <= LD_DONE;
                default: ldState_q <= LD_IDLE;
            endcase
        end
    end

    // Fetch request; held until acknowledged
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            nvmReq  <= 1'b0;
            nvmAddr <= 16'h0000;
        end else begin
            nvmReq  <= (ldState_q == LD_REQ) ||
                       (ldState_q == LD_WAIT && !nvmAck);
            nvmAddr <= CFG_BASE + 16'({12'h000, ldIdx_q} * CFG_STEP);
        end
    end

    // Shadow capture; erased value until loaded, frozen once done
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < NUM_WORDS; i++) begin
                shadow_q[i] <= ERASED_WORD;
            end
        end else if (ldState_q == LD_WAIT && nvmAck) begin
            shadow_q[ldIdx_q] <= fixWord(ldIdx_q, nvmData);
        end
    end

    // =========================================================================
    // Decode, combinational from shadow words
    cfg_ctrl_t ctrl_d;
    logic [23:0] wDbg, wWin, wWd, wOsc, wSel, wSeg;
    assign wDbg = shadow_q[2];
    assign wWin = shadow_q[3];
    assign wWd  = shadow_q[4];
    assign wOsc = shadow_q[5];
    assign wSel = shadow_q[6];
    assign wSeg = shadow_q[7];

    always_comb begin
        ctrl_d = '0;
        ctrl_d.codeProtect     = !wSeg[SP_CP_BIT];
        ctrl_d.writeProtect    = !wSeg[SP_WRP_BIT];
        ctrl_d.twoSpeedStartup = wSel[OSL_2SPD_BIT];
        ctrl_d.pwmKeyLock      = wSel[OSL_PWML_BIT];
        ctrl_d.oscillatorSelect =
            clk_src_t'(wSel[OSL_SEL_LSB +: 3]);
        ctrl_d.clockSwitchEn   = !wOsc[OS_CKSM_LSB + 1];
        ctrl_d.failSafeEn      = (wOsc[OS_CKSM_LSB +: 2] == 2'b00);
        ctrl_d.oneWayRemap     = wOsc[OS_1WAY_BIT];
        ctrl_d.primaryOscMode  =
            pri_mode_t'(wOsc[OS_PMODE_LSB +: 2]);
        // Crystal modes own the pin, so clock-out is suppressed there
        ctrl_d.oscPinClockOut  = wOsc[OS_PINF_BIT] &&
            (ctrl_d.primaryOscMode != PRI_XTAL) &&
            (ctrl_d.primaryOscMode != PRI_HS_XTAL);
        ctrl_d.watchdogAlwaysOn = wWd[WD_AON_BIT];
        ctrl_d.watchdogWindowed = !wWd[WD_WDIS_BIT];
        ctrl_d.prescaleDiv = wWd[WD_PRE_BIT] ? PRESCALE_LONG
                                             : PRESCALE_SHORT;
        ctrl_d.postscaleShift = wWd[WD_POST_LSB +: 4];
        ctrl_d.pllLockEn      = wWd[WD_PLLK_BIT];
        case (wWin[WP_WIN_LSB +: 2])
            2'b11:   ctrl_d.windowEighths = 4'h2;
            2'b10:   ctrl_d.windowEighths = 4'h3;
            2'b01:   ctrl_d.windowEighths = 4'h4;
            default: ctrl_d.windowEighths = 4'h6;
        endcase
        ctrl_d.port1PrimaryPins = wWin[WP_I2C1_BIT];
        ctrl_d.port2PrimaryPins = wWin[WP_I2C2_BIT];
        case (wDbg[DBG_CH_LSB +: 2])
            2'b11:   ctrl_d.debugPair = 2'd1;
            2'b10:   ctrl_d.debugPair = 2'd2;
            2'b01:   ctrl_d.debugPair = 2'd3;
            default: ctrl_d.debugPair = 2'd0;  // Illegal code, no pair
        endcase
        ctrl_d.boundaryScanEn = wDbg[DBG_BSCAN_BIT];
    end

    // =========================================================================
    // Output registers; only updated while loading so values stay put after
    logic loadDone;
    assign loadDone = (ldState_q == LD_DONE);

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            cfgCtrl     <= '0;
            configValid <= 1'b0;
        end else if (!configValid) begin
            cfgCtrl     <= ctrl_d;
            configValid <= loadDone;
        end
    end

    // Watchdog and slow RC enables follow the always-on bit or software; slow RC also runs while CLK_LOW_POWER_RC is selected
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            watchdogRun   <= 1'b0;
            lowPowerRcRun <= 1'b0;
        end else begin
            watchdogRun   <= configValid &&
                (cfgCtrl.watchdogAlwaysOn || watchdogSoftEnable);
            lowPowerRcRun <= configValid &&
                (cfgCtrl.watchdogAlwaysOn || watchdogSoftEnable ||
                 cfgCtrl.oscillatorSelect == CLK_LOW_POWER_RC);
        end
    end

    // Two-speed start: run from fast RC until the chosen source is ready
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            useFastRcStart <= 1'b0;
        end else begin
            useFastRcStart <= configValid && cfgCtrl.twoSpeedStartup &&
                              !primaryClockReady;
        end
    end

    // =========================================================================
    // AHB-Lite slave: one wait state on reads, none on writes, read-only, OKAY always
    logic        aValid_q;
    logic [13:0] aIdx_q;
    logic [31:0] rdMux;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            aValid_q <= 1'b0;
            aIdx_q   <= 14'h0000;
        end else if (hready) begin
            aValid_q <= hsel && htrans[1] && !hwrite;
            aIdx_q   <= haddr[15:2];
        end
    end

    // Byte address = index * 4; writes are silently dropped
    always_comb begin
        rdMux = 32'h00000000;
        for (int i = 0; i < NUM_WORDS; i++) begin
            if (aIdx_q == 14'(CFG_BASE + 16'(i) * CFG_STEP)) begin
                rdMux = {8'h00, shadow_q[i]};
            end
        end
        if (aIdx_q == IDX_PART_ID[13:0]) begin
            rdMux = {8'h00, PART_ID};
        end
        if (aIdx_q == IDX_PART_REV[13:0]) begin
            rdMux = {8'h00, PART_REV};
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            hrdata <= 32'h00000000;
        end else if (hready) begin
            hrdata <= 32'h00000000;
        end else if (aValid_q) begin
            hrdata <= rdMux;
        end
    end

    // Single wait state lets read data come from a flip-flop
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            hreadyout <= 1'b1;
        end else begin
            hreadyout <= !(hready && hsel && htrans[1] && !hwrite);
        end
    end

    // Response held at OKAY from a flop so the output stays registered
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            hresp <= 1'b0;
        end else begin
            hresp <= 1'b0;
        end
    end

    logic unusedBits;
    assign unusedBits = ^{hsize, hwdata, haddr[31:16], haddr[1:0]};

    // =========================================================================
    // Checks
    a_load_freeze: assert property (
        @(posedge mclk) disable iff (!nrst)
        configValid |=> $stable(cfgCtrl))
        else $error("controls changed after load");
    a_unimpl_ones: assert property (
        @(posedge mclk) disable iff (!nrst)
        loadDone |-> (shadow_q[7][23:2] == 22'h3fffff))
        else $error("unimplemented bit reads zero");
    a_code_prot: assert property (
        @(posedge mclk) disable iff (!nrst)
        $rose(configValid) |-> cfgCtrl.codeProtect == !wSeg[SP_CP_BIT])
        else $error("code protect wrong");
    a_write_prot: assert property (
        @(posedge mclk) disable iff (!nrst)
        $rose(configValid) |-> cfgCtrl.writeProtect == !wSeg[SP_WRP_BIT])
        else $error("write protect wrong");
    a_wdog_force: assert property (
        @(posedge mclk) disable iff (!nrst)
        configValid && cfgCtrl.watchdogAlwaysOn |=> watchdogRun)
        else $error("watchdog not forced on");
    a_fail_safe: assert property (
        @(posedge mclk) disable iff (!nrst)
        configValid |-> !(cfgCtrl.failSafeEn && !cfgCtrl.clockSwitchEn))
        else $error("monitor without switching");
    a_presc_val: assert property (
        @(posedge mclk) disable iff (!nrst)
        configValid |-> cfgCtrl.prescaleDiv inside {8'h20, 8'h80})
        else $error("bad prescale");
    a_reload_start: assert property (
        @(posedge mclk) disable iff (!nrst)
        $rose(nrst) |-> !configValid ##2 nvmReq)
        else $error("no reload after reset");
    a_pin_xtal: assert property (
        @(posedge mclk) disable iff (!nrst)
        cfgCtrl.primaryOscMode inside {PRI_XTAL, PRI_HS_XTAL}
        |-> !cfgCtrl.oscPinClockOut)
        else $error("clock out in crystal mode");
    a_read_id: assert property (
        @(posedge mclk) disable iff (!nrst)
        aValid_q && !hready && aIdx_q == IDX_PART_ID[13:0]
        |=> hrdata == {8'h00, PART_ID})
        else $error("identifier read wrong");
    a_read_rev: assert property (
        @(posedge mclk) disable iff (!nrst)
        aValid_q && !hready && aIdx_q == IDX_PART_REV[13:0]
        |=> hrdata == {8'h00, PART_REV})
        else $error("revision read wrong");
    a_two_speed: assert property (
        @(posedge mclk) disable iff (!nrst)
        configValid && !cfgCtrl.twoSpeedStartup |=> !useFastRcStart)
        else $error("fast RC start without two-speed bit");
    a_pwm_lock: assert property (
        @(posedge mclk) disable iff (!nrst)
        $rose(configValid) |-> cfgCtrl.pwmKeyLock == wSel[OSL_PWML_BIT])
        else $error("PWM lock wrong");
    a_osc_select: assert property (
        @(posedge mclk) disable iff (!nrst)
        $rose(configValid) |->
        cfgCtrl.oscillatorSelect == wSel[OSL_SEL_LSB +: 3])
        else $error("oscillator select wrong");
    a_switch_off: assert property (
        @(posedge mclk) disable iff (!nrst)
        configValid && wOsc[OS_CKSM_LSB + 1] |->
        !cfgCtrl.clockSwitchEn && !cfgCtrl.failSafeEn)
        else $error("switching left on by mode 1x");
    a_remap_once: assert property (
        @(posedge mclk) disable iff (!nrst)
        $rose(configValid) |-> cfgCtrl.oneWayRemap == wOsc[OS_1WAY_BIT])
        else $error("one-way remap wrong");
    a_pri_mode: assert property (
        @(posedge mclk) disable iff (!nrst)
        configValid |-> cfgCtrl.primaryOscMode == wOsc[OS_PMODE_LSB +: 2])
        else $error("primary mode wrong");
    a_wdog_window: assert property (
        @(posedge mclk) disable iff (!nrst)
        configValid |-> cfgCtrl.watchdogWindowed != wWd[WD_WDIS_BIT])
        else $error("window mode wrong");
    a_post_scale: assert property (
        @(posedge mclk) disable iff (!nrst)
        configValid |-> cfgCtrl.postscaleShift == wWd[WD_POST_LSB +: 4])
        else $error("postscale wrong");
    a_window_size: assert property (
        @(posedge mclk) disable iff (!nrst)
        configValid && wWin[WP_WIN_LSB +: 2] == 2'b00 |->
        cfgCtrl.windowEighths == 4'h6)
        else $error("window size wrong");
    a_port_pins: assert property (
        @(posedge mclk) disable iff (!nrst)
        configValid |-> cfgCtrl.port1PrimaryPins == wWin[WP_I2C1_BIT])
        else $error("serial port pins wrong");
    a_debug_pair: assert property (
        @(posedge mclk) disable iff (!nrst)
        configValid && wDbg[DBG_CH_LSB +: 2] == 2'b11 |->
        cfgCtrl.debugPair == 2'd1)
        else $error("debug pair wrong");

    // Cover points for the main scenarios
    c_load_done:  cover property (@(posedge mclk) $rose(configValid));
    c_reg_read:   cover property (@(posedge mclk) aValid_q && hreadyout);
    c_two_speed:  cover property (@(posedge mclk) $fell(useFastRcStart));
    c_fail_safe:  cover property (@(posedge mclk) cfgCtrl.failSafeEn);
    c_load_cut:   cover property (@(posedge mclk) $fell(nrst) && nvmReq);

endmodule

// *** tb/nonvolatile_config_word_decode_tb.sv ***
// Self-checking bench for the configuration word loader and decoder
`timescale 1ns/100ps
module nonvolatile_config_word_decode_tb;
    import cfg_word_pkg::*;

    // =====================================================================
    // Signals and stimulus table
    typedef struct packed {
        logic [5:0][7:0] w;    // Debug, winpin, wdog, osc, oscsel, segprot
        logic [3:0]      eWin;
        logic [1:0]      eDbg;
        logic [1:0]      eCsw; // Switch enable, fail-safe enable
    } row_t;
    localparam logic [23:0] ID_VAL  = 24'h3c5a12; // Arbitrary value
    localparam logic [23:0] REV_VAL = 24'h000b07; // Arbitrary value
    localparam logic [23:0] MASKS [6] = '{MASK_DEBUG, MASK_WINPIN,
        MASK_WDOG, MASK_OSC, MASK_OSCSEL, MASK_SEGPROT};
    logic        mclk, nrst, nvmReq, nvmAck, configValid, hsel, hwrite;
    logic        watchdogSoftEnable, primaryClockReady, hreadyout, hresp;
    logic        watchdogRun, lowPowerRcRun, useFastRcStart;
    logic [15:0] nvmAddr;
    logic [23:0] nvmData;
    logic [23:0] flash [10];
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, hrdata, rd;
    wire         hready;
    cfg_ctrl_t   cfgCtrl;
    row_t        rows [6];
    int          n_mismatch, checks_done, cyc, ackIdx;

    assign hready = hreadyout; // Sole slave drives the bus ready

    nonvolatile_config_word_decode #(.PART_ID(ID_VAL), .PART_REV(REV_VAL))
    dut (
        .mclk(mclk), .nrst(nrst), .nvmReq(nvmReq), .nvmAddr(nvmAddr),
        .nvmAck(nvmAck), .nvmData(nvmData),
        .watchdogSoftEnable(watchdogSoftEnable),
        .primaryClockReady(primaryClockReady), .cfgCtrl(cfgCtrl),
        .configValid(configValid), .watchdogRun(watchdogRun),
        .lowPowerRcRun(lowPowerRcRun), .useFastRcStart(useFastRcStart),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp)
    );

    // =====================================================================
    // Clock, flash responder and hang guard
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    // One-cycle ack; data scrambled when not valid so stale values fail
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            nvmAck <= 1'b0;
            ackIdx <= 0;
        end else if (nvmReq && !nvmAck) begin
            chk(nvmAddr, CFG_BASE + 16'(2 * ackIdx));
            nvmAck  <= 1'b1;
            nvmData <= flash[ackIdx];
            ackIdx  <= ackIdx + 1;
        end else begin
            nvmAck  <= 1'b0;
            nvmData <= ~nvmData;
        end
    end

    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            $display("Error at %0t: run timed out", $time);
            summarize();
        end
    end

    // =====================================================================
    // Tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic summarize();
        $display("Checks %0d, mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Single word transfer; request held until ready seen high
    task automatic bus(input logic wr, input logic [15:0] idx,
                       input logic [31:0] wd, output logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= {14'h0, idx, 2'b00};
        htrans <= 2'b10;
        hwrite <= wr;
        // Only the run timeout ends a wait for ready
        do @(posedge mclk); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge mclk); while (hready !== 1'b1);
        d = hrdata;
        chk(hresp, 1'b0);
    endtask

    // Unimplemented bits stored as zero to prove they read as one
    task automatic loadRow(input row_t r);
        for (int k = 0; k < 10; k++) flash[k] = 24'h000000;
        for (int k = 0; k < 6; k++) flash[2 + k] = {16'h0000, r.w[5 - k]};
    endtask

    task automatic doReset();
        watchdogSoftEnable <= 1'b0;
        primaryClockReady  <= 1'b0;
        nrst <= 1'b0;
        repeat (3) @(posedge mclk);
        chk({configValid, nvmReq, watchdogRun, hreadyout}, 4'b0001);
        chk(cfgCtrl != '0, 1'b0);
        nrst <= 1'b1;
        do @(posedge mclk); while (configValid !== 1'b1);
        chk(ackIdx, 10);
    endtask

    task automatic checkCtl(input row_t r);
        logic [7:0]  dbg, win, wd, osc, sel, seg;
        logic [31:0] d;
        {dbg, win, wd, osc, sel, seg} = r.w;
        chk(cfgCtrl.codeProtect, !seg[1]);
        chk(cfgCtrl.writeProtect, !seg[0]);
        chk(cfgCtrl.twoSpeedStartup, sel[7]);
        chk(cfgCtrl.pwmKeyLock, sel[6]);
        chk(cfgCtrl.oscillatorSelect, sel[2:0]);
        chk({cfgCtrl.clockSwitchEn, cfgCtrl.failSafeEn}, r.eCsw);
        chk(cfgCtrl.oneWayRemap, osc[5]);
        chk(cfgCtrl.oscPinClockOut, osc[2] && osc[1] == osc[0]);
        chk(cfgCtrl.primaryOscMode, osc[1:0]);
        chk(cfgCtrl.watchdogAlwaysOn, wd[7]);
        chk(cfgCtrl.watchdogWindowed, !wd[6]);
        chk(cfgCtrl.prescaleDiv, wd[4] ? 128 : 32);
        chk(cfgCtrl.postscaleShift, wd[3:0]);
        chk(cfgCtrl.windowEighths, r.eWin);
        chk({cfgCtrl.port2PrimaryPins, cfgCtrl.port1PrimaryPins},
            win[5:4]);
        chk(cfgCtrl.debugPair, r.eDbg);
        for (int k = 0; k < 6; k++) begin
            bus(1'b0, IDX_DEBUG + 16'(2 * k), 32'h0, d);
            chk(d, {8'h00, {16'h0000, r.w[5 - k]} | ~MASKS[k]});
        end
    endtask

    // =====================================================================
    // Main sequence
    initial begin
        nrst = 1'b0;
        nvmAck = 1'b0;
        nvmData = 24'h0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
        watchdogSoftEnable = 1'b0;
        primaryClockReady = 1'b0;
        n_mismatch = 0;
        checks_done = 0;
        cyc = 0;
        // Reserved debug bit kept zero, reserved codes never used
        rows[0] = '{48'h23f09fe4c703, 4'd2, 2'd1, 2'b00};
        rows[1] = '{48'h02806045_0500, 4'd3, 2'd2, 2'b10};
        rows[2] = '{48'h215017068301, 4'd4, 2'd3, 2'b11};
        rows[3] = '{48'h23204a874202, 4'd6, 2'd1, 2'b00};
        rows[4] = '{48'h23f09f000103, 4'd2, 2'd1, 2'b11};
        rows[5] = '{48'h028060c30000, 4'd3, 2'd2, 2'b00};
        for (int i = 0; i < 6; i++) begin
            loadRow(rows[i]);
            doReset();
            checkCtl(rows[i]);
            chk(watchdogRun, rows[i].w[3][7]);
            // Slow RC also runs while it is the selected system clock
            chk(lowPowerRcRun, rows[i].w[3][7] ||
                rows[i].w[1][2:0] == 3'b101);
            chk(useFastRcStart, rows[i].w[1][7]);
            watchdogSoftEnable <= 1'b1;
            primaryClockReady  <= 1'b1;
            repeat (3) @(posedge mclk);
            chk({watchdogRun, lowPowerRcRun}, 2'b11);
            chk(useFastRcStart, 1'b0);
            $display("Row %0d done", i);
        end
        // Flash rewritten without a reset: controls must not follow
        loadRow(rows[0]);
        repeat (20) @(posedge mclk);
        checkCtl(rows[5]);
        doReset();
        checkCtl(rows[0]);
        $display("Frozen controls and reload done");
        // Writes are ignored; identity, reserved and unmapped reads
        bus(1'b1, IDX_OSCSEL, 32'h0, rd);
        bus(1'b1, IDX_PART_ID, 32'h0, rd);
        checkCtl(rows[0]);
        bus(1'b0, IDX_PART_ID, 32'h0, rd);
        chk(rd, {8'h00, ID_VAL});
        bus(1'b0, IDX_PART_REV, 32'h0, rd);
        chk(rd, {8'h00, REV_VAL});
        for (int k = 0; k < 4; k++) begin
            bus(1'b0, k < 2 ? IDX_RSVD_A + 16'(2 * k)
                            : IDX_RSVD_C + 16'(2 * k - 4), 32'h0, rd);
            chk(rd, 32'h00ffffff);
        end
        bus(1'b0, 16'h1234, 32'h0, rd);
        chk(rd, 32'h0);
        $display("Bus access cases done");
        // Reset cutting into a load in progress
        loadRow(rows[1]);
        nrst <= 1'b0;
        @(posedge mclk);
        nrst <= 1'b1;
        repeat (8) @(posedge mclk);
        doReset();
        checkCtl(rows[1]);
        $display("Reset during load done");
        summarize();
    end
endmodule
